/* src/swc_pkg.sv */
/*
 * constants shared by the reference-window capture block and its tap detector.
 * assumes a byte-wide register read port and 24 delayed sample taps from a delay line.
 */
package swc_pkg;
    localparam int POSITIONS = 24;
    localparam int SEL_W = 4;
    localparam int SEL_POSITIONS = 16;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_LOW = 12'h02C;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_MID = 12'h02D;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_HIGH = 12'h02E;
    localparam int LOW_LSB = 0;
    localparam int MID_LSB = 8;
    localparam int HIGH_LSB = 16;
    localparam logic [POSITIONS-1:0] FLAGS_RESET = 24'h800001;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;
    localparam logic [POSITIONS-1:0] TAPS_ZERO = 24'h000000;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
endpackage

/* src/swc_tap_if.sv */
/*
 * carrier between the tap detector and the capture top.
 * assumes both ends sit on the same device clock.
 */
`timescale 1ns/1ps
interface swc_tap_if #(parameter int N = 24);
    logic [N-1:0] taps_now;
    logic [N-1:0] taps_prev;
    logic [N-1:0] pos_flags;
    logic edge_seen;
    modport src (output taps_now, output taps_prev, output pos_flags, output edge_seen);
    modport dst (input taps_now, input taps_prev, input pos_flags, input edge_seen);
endinterface

/* src/swc_tap_detect.sv */
/*
 * synchronises the delayed reference samples and judges each sampling position.
 * assumes tap i is the reference sampled by the clock delayed i steps, asynchronous here.
 */
`timescale 1ns/1ps
module swc_tap_detect #(
    parameter int N = 24
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [N-1:0] taps_i,
    swc_tap_if.src tap
);
    logic [N-1:0] meta_r;
    logic [N-1:0] sync_r;
    logic [N-1:0] prev_r;

    initial begin
        if (N < 3) begin
            $error("need at least three sampling positions");
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= taps_i;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign tap.taps_now = sync_r;
    assign tap.taps_prev = prev_r;
    // a new rising reference edge reaches at least one tap: pulse or periodic alike
    assign tap.edge_seen = |(sync_r & ~prev_r);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pos
            if (i == 0 || i == N - 1) begin : g_end
                assign tap.pos_flags[i] = 1'b1;
            end else begin : g_mid
                // a neighbour differing means the edge sits near this position
                assign tap.pos_flags[i] = (sync_r[i] != sync_r[i-1]) ||
                    (sync_r[i] != sync_r[i+1]);
            end
        end
    endgenerate
endmodule

/* src/swc_capture.sv */
/*
 * reference windowing: position status, selectable sampling tap, status read port.
 * assumes the delay line outside provides taps at coarse or fine spacing per fine_step_o.
 */
`timescale 1ns/1ps
// Summary of operation
// - capture reference on one deterministic selected edge
// - record reference position as 24-bit vector
// - flag 1 marks possible violation, 0 valid
// - sample reference with selected delayed clock tap
// - fine step 0 coarse spacing, 1 fine
// - extreme bits 0 and 23 always one
// - select value is decimal bit index
// - selection reaches only positions 0 to 15
// - status readable as read-only register bytes
module swc_capture #(
    parameter int N = swc_pkg::POSITIONS
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [N-1:0] ref_taps_i,
    input wire logic [swc_pkg::SEL_W-1:0] ref_sample_select_i,
    input wire logic ref_delay_fine_step_i,
    input wire logic reg_rd_i,
    input wire logic [swc_pkg::ADDR_W-1:0] reg_addr_i,
    output logic [swc_pkg::DATA_W-1:0] reg_rdata_o,
    output logic [N-1:0] ref_position_flags_o,
    output logic [swc_pkg::SEL_W-1:0] ref_sample_select_o,
    output logic ref_delay_fine_step_o,
    output logic ref_capture_o
);
    swc_tap_if #(.N(N)) tap ();

    logic [N-1:0] ref_position_flags_r;
    logic [swc_pkg::SEL_W-1:0] sel_r;
    logic fine_r;
    logic capture_r;
    logic [swc_pkg::DATA_W-1:0] rdata_r;
    logic [swc_pkg::DATA_W-1:0] rdata_nxt;
    logic sel_rise;

    initial begin
        if (N != swc_pkg::POSITIONS) begin
            $error("status layout serves exactly 24 positions");
        end
    end

    swc_tap_detect #(.N(N)) u_detect (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .taps_i(ref_taps_i),
        .tap(tap.src)
    );

    // control settings; 4-bit select can only name positions 0 to 15
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_r <= swc_pkg::SEL_RESET;
            fine_r <= 1'b0;
        end else begin
            sel_r <= ref_sample_select_i;
            fine_r <= ref_delay_fine_step_i;
        end
    end

    // deterministic capture at the selected tap's rising edge
    assign sel_rise = tap.taps_now[sel_r] && !tap.taps_prev[sel_r];

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            capture_r <= 1'b0;
        end else begin
            capture_r <= sel_rise;
        end
    end

    // position status refreshed on each rising reference edge, never written
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ref_position_flags_r <= swc_pkg::FLAGS_RESET;
        end else if (tap.edge_seen) begin
            ref_position_flags_r <= tap.pos_flags;
        end
    end

    // byte read port
    always_comb begin
        rdata_nxt = swc_pkg::READ_ZERO;
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                swc_pkg::OFS_FLAGS_LOW:
                    rdata_nxt = ref_position_flags_r[swc_pkg::LOW_LSB +: swc_pkg::DATA_W];
                swc_pkg::OFS_FLAGS_MID:
                    rdata_nxt = ref_position_flags_r[swc_pkg::MID_LSB +: swc_pkg::DATA_W];
                swc_pkg::OFS_FLAGS_HIGH:
                    rdata_nxt = ref_position_flags_r[swc_pkg::HIGH_LSB +: swc_pkg::DATA_W];
                default:
                    rdata_nxt = swc_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= swc_pkg::READ_ZERO;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign ref_position_flags_o = ref_position_flags_r;
    assign ref_sample_select_o = sel_r;
    assign ref_delay_fine_step_o = fine_r;
    assign ref_capture_o = capture_r;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence rd_at(logic [swc_pkg::ADDR_W-1:0] a);
        reg_rd_i && reg_addr_i == a;
    endsequence

    sequence sel_tap_rises;
        tap.taps_now[sel_r] && !tap.taps_prev[sel_r];
    endsequence

    sequence capture_pulse;
        ref_capture_o ##1 !ref_capture_o;
    endsequence

    sequence flat_snapshot;
        tap.edge_seen && (&tap.taps_now);
    endsequence

    sequence rd_unmapped;
        reg_rd_i && reg_addr_i != swc_pkg::OFS_FLAGS_LOW &&
            reg_addr_i != swc_pkg::OFS_FLAGS_MID && reg_addr_i != swc_pkg::OFS_FLAGS_HIGH;
    endsequence

    chk_end_bits_set: assert property (
        ref_position_flags_r[0] && ref_position_flags_r[N-1])
        else $error("extreme position bits not set");
    chk_capture_after_rise: assert property (
        sel_rise |=> ref_capture_o)
        else $error("selected tap rise not captured");
    chk_capture_has_cause: assert property (
        ref_capture_o |-> $past(tap.taps_now[sel_r] && !tap.taps_prev[sel_r]))
        else $error("capture without selected tap rise");
    chk_status_refresh: assert property (
        tap.edge_seen |=> ref_position_flags_r == $past(tap.pos_flags))
        else $error("status not refreshed on edge");
    chk_status_hold: assert property (
        !tap.edge_seen |=> $stable(ref_position_flags_r))
        else $error("status changed without edge");
    chk_read_low_byte: assert property (
        rd_at(swc_pkg::OFS_FLAGS_LOW) |=>
            reg_rdata_o == $past(ref_position_flags_r[swc_pkg::LOW_LSB +: swc_pkg::DATA_W]))
        else $error("low status byte wrong");
    chk_read_high_byte: assert property (
        rd_at(swc_pkg::OFS_FLAGS_HIGH) |=>
            reg_rdata_o == $past(ref_position_flags_r[swc_pkg::HIGH_LSB +: swc_pkg::DATA_W]))
        else $error("high status byte wrong");
    chk_read_idle_zero: assert property (
        !reg_rd_i |=> reg_rdata_o == swc_pkg::READ_ZERO)
        else $error("read data not zero when idle");
    chk_fine_step_follow: assert property (
        ref_delay_fine_step_i |=> ref_delay_fine_step_o)
        else $error("fine step not applied");

    // capture timing
    chk_capture_single: assert property (
        sel_tap_rises |=> capture_pulse)
        else $error("capture not a single pulse");
    chk_capture_needs_edge: assert property (
        ref_capture_o |-> $past(tap.edge_seen))
        else $error("capture without reference edge");
    chk_capture_idle: assert property (
        !sel_rise |=> !ref_capture_o)
        else $error("capture without selected rise");
    chk_sync_latency: assert property (
        tap.edge_seen |-> tap.taps_now == $past(ref_taps_i, 2))
        else $error("tap latency not two edges");
    chk_above_sel_no_capture: assert property (
        tap.edge_seen && !(|(tap.taps_now[swc_pkg::SEL_POSITIONS-1:0] &
            ~tap.taps_prev[swc_pkg::SEL_POSITIONS-1:0])) |=> !ref_capture_o)
        else $error("capture from informational tap");

    // status, read port and control settings
    chk_flat_all_valid: assert property (
        flat_snapshot |=> ref_position_flags_r == swc_pkg::FLAGS_RESET)
        else $error("uniform taps flagged");
    chk_low_mid_flag: assert property (
        tap.edge_seen |=> ref_position_flags_r[1] ==
            $past((tap.taps_now[1] != tap.taps_now[0]) || (tap.taps_now[1] != tap.taps_now[2])))
        else $error("low middle flag wrong");
    chk_top_mid_flag: assert property (
        tap.edge_seen |=> ref_position_flags_r[N-2] == $past((tap.taps_now[N-2] !=
            tap.taps_now[N-3]) || (tap.taps_now[N-2] != tap.taps_now[N-1])))
        else $error("top middle flag wrong");
    chk_status_read_stable: assert property (
        reg_rd_i && !tap.edge_seen |=> $stable(ref_position_flags_r))
        else $error("status changed by read");
    chk_read_mid_byte: assert property (
        rd_at(swc_pkg::OFS_FLAGS_MID) |=>
            reg_rdata_o == $past(ref_position_flags_r[swc_pkg::MID_LSB +: swc_pkg::DATA_W]))
        else $error("middle status byte wrong");
    chk_read_unmapped: assert property (
        rd_unmapped |=> reg_rdata_o == swc_pkg::READ_ZERO)
        else $error("unmapped read not zero");
    chk_read_one_cycle: assert property (
        rd_at(swc_pkg::OFS_FLAGS_LOW) ##1 !reg_rd_i |=> reg_rdata_o == swc_pkg::READ_ZERO)
        else $error("read data stands too long");
    chk_select_follow: assert property (
        1'b1 |=> ref_sample_select_o == $past(ref_sample_select_i))
        else $error("select not applied");
    chk_fine_step_clear: assert property (
        !ref_delay_fine_step_i |=> !ref_delay_fine_step_o)
        else $error("coarse step not applied");
endmodule

/* test/swc_ref_gen.sv */
/*
 * model of the external clock generator as the delay line presents it: 24 delayed taps.
 * assumes the bench calls fire just after a clock edge; taps change only then.
 */
`timescale 1ns/1ps
module swc_ref_gen (
    input wire logic ref_clk_i,
    output logic [23:0] taps_o
);
    initial taps_o = 24'h000000;
    // one reference pulse per pass; n above 1 gives a periodic reference
    task automatic fire(input int p, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge ref_clk_i);
            #1;
            taps_o = ~((24'h000001 << p) - 24'h000001);
            repeat (3) @(posedge ref_clk_i);
            #1;
            taps_o = 24'h000000;
            repeat (3) @(posedge ref_clk_i);
        end
    endtask
endmodule

/* test/tb.sv */
/*
 * self-checking bench for the reference-window capture block.
 * assumes swc_ref_gen stands in for the clock generator on the tap inputs.
 */
`timescale 1ns/1ps
module tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [23:0] taps;
    logic [3:0] sel = 4'h0;
    logic fine = 1'b0;
    logic rd = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [7:0] rdata;
    logic [23:0] flags;
    logic [3:0] sel_o;
    logic fine_o;
    logic cap;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    int caps = 0;
    always #20 ref_clk_i = ~ref_clk_i;
    swc_ref_gen u_gen (.ref_clk_i(ref_clk_i), .taps_o(taps));
    swc_capture u_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .ref_taps_i(taps),
        .ref_sample_select_i(sel), .ref_delay_fine_step_i(fine), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_rdata_o(rdata), .ref_position_flags_o(flags),
        .ref_sample_select_o(sel_o), .ref_delay_fine_step_o(fine_o), .ref_capture_o(cap));
    task automatic conclude();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cap === 1'b1) begin
            caps <= caps + 1;
        end
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            conclude();
        end
    end
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one read strobe, data the next cycle, zero after
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rd = 1'b0;
        check({16'h0000, rdata}, {16'h0000, exp});
        @(posedge ref_clk_i);
        #1;
        check({16'h0000, rdata}, 24'h000000);
    endtask
    // reset values and status bytes before any reference
    task automatic t_reset();
        check(flags, 24'h800001);
        check({18'h0, sel_o, fine_o, cap}, 24'h000000);
        arst_n_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
        rd_chk(12'h02C, 8'h01);
        rd_chk(12'h02D, 8'h00);
        rd_chk(12'h02E, 8'h80);
        rd_chk(12'h02F, 8'h00);
    endtask
    // reference at position p, select s, n pulses, ecap captures expected
    task automatic t_pos(input int p, input logic [3:0] s, input int n, input int ecap,
        input logic f);
        logic [23:0] e;
        int c0;
        e = 24'h800001 | (24'h000001 << p) | (24'h000001 << (p - 1));
        sel = s;
        fine = f;
        @(posedge ref_clk_i);
        #1;
        check({20'h00000, sel_o}, {20'h00000, s});
        check({23'h000000, fine_o}, {23'h000000, fine});
        c0 = caps;
        u_gen.fire(p, n);
        repeat (4) @(posedge ref_clk_i);
        #1;
        check(flags, e);
        rd_chk(12'h02C, e[7:0]);
        rd_chk(12'h02D, e[15:8]);
        rd_chk(12'h02E, e[23:16]);
        check(24'(caps - c0), 24'(ecap));
    endtask
    // mid-run reset, select 7 applied, a reference at position 6, then a flat snapshot
    task automatic t_repower();
        int c0;
        arst_n_i = 1'b0;
        @(posedge ref_clk_i);
        #1;
        check(flags, 24'h800001);
        check({18'h0, sel_o, fine_o, cap}, 24'h000000);
        arst_n_i = 1'b1;
        sel = 4'h7;
        fine = 1'b0;
        @(posedge ref_clk_i);
        #1;
        check({19'h0, sel_o, fine_o}, {19'h0, 4'h7, 1'b0});
        c0 = caps;
        u_gen.fire(6, 1);
        repeat (4) @(posedge ref_clk_i);
        #1;
        check(flags, 24'h800061);
        u_gen.fire(0, 1);
        repeat (4) @(posedge ref_clk_i);
        #1;
        check(flags, 24'h800001);
        check(24'(caps - c0), 24'h000002);
    endtask
    initial begin
        repeat (5) @(posedge ref_clk_i);
        #1;
        t_reset();
        t_pos(4, 4'hF, 1, 1, 1'b1);
        t_pos(9, 4'hC, 2, 2, 1'b1);
        t_pos(20, 4'hF, 1, 0, 1'b0);
        t_pos(1, 4'h0, 1, 0, 1'b1);
        t_repower();
        conclude();
    end
endmodule
